// ---- src/ssi_core.sv ----
`timescale 1ns/1ps
`include "ssi_consts.svh"
module ssi_core #(
    parameter int HALF_SEC_CYCLES = `SSI_CLK_HZ / `SSI_MS_PER_SEC * `SSI_HALF_SEC_MS,
    parameter int WARN_PHASES     = `SSI_WARN_LIMIT_MIN * `SSI_PHASES_PER_MIN,
    parameter int PROTECT_PHASES  = `SSI_PROTECT_MIN * `SSI_PHASES_PER_MIN
) (
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rstn_in,
    // supply and safety inputs
    input  wire logic supply_ok_in,
    input  wire logic safety_input_a_in,
    input  wire logic safety_input_b_in,
    // actuator sensing
    input  wire logic actuator_present_in,
    input  wire logic limit_zone_in,
    // warning causes
    input  wire logic fault_output_a_in,
    input  wire logic fault_output_b_in,
    input  wire logic cross_wire_in,
    input  wire logic over_temp_in,
    input  wire logic bad_actuator_in,
    // internal error and teach status
    input  wire logic internal_fault_in,
    input  wire logic teach_active_in,
    input  wire logic teach_done_in,
    // indicators
    output logic      led_green_out,
    output logic      led_red_out,
    output logic      led_yellow_out,
    // diagnostic and safety outputs
    output logic      diag_out,
    output logic      safety_output_a_out,
    output logic      safety_output_b_out
);
    logic [`SSI_IN_COUNT-1:0] raw;
    logic [`SSI_IN_COUNT-1:0] meta;
    logic [`SSI_IN_COUNT-1:0] s;
    logic                     tick;
    logic                     blink;

    // status state
    logic        err_latched;
    logic        next_err_latched;
    logic        guard_opened;
    logic        next_guard_opened;
    logic [31:0] warn_count;
    logic [31:0] next_warn_count;
    logic        warn_expired;
    logic        next_warn_expired;
    logic [31:0] protect_count;
    logic [31:0] next_protect_count;
    logic        taught_prev;
    logic        next_taught_prev;
    // pulse code sequencer
    ssi_pkg::ssi_code_state_t code_state;
    ssi_pkg::ssi_code_state_t next_code_state;
    logic [2:0]  pulse_count;
    logic [2:0]  next_pulse_count;
    logic [2:0]  active_code;
    logic [2:0]  next_active_code;
    // registered outputs
    logic        green;
    logic        next_green;
    logic        red;
    logic        next_red;
    logic        yellow;
    logic        next_yellow;
    logic        diag;
    logic        next_diag;
    logic        enable;
    logic        next_enable;

    // combinational helpers
    logic        inputs_ok;
    logic        ready;
    logic        warning;
    logic        protect;
    logic [2:0]  code;

    assign raw = {teach_done_in, teach_active_in, internal_fault_in, bad_actuator_in,
                  over_temp_in, cross_wire_in, fault_output_b_in, fault_output_a_in,
                  limit_zone_in, actuator_present_in, safety_input_b_in,
                  safety_input_a_in, supply_ok_in};

    // every pin comes from outside the clock domain
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            meta <= '0;
            s    <= '0;
        end else begin
            meta <= raw;
            s    <= meta;
        end
    end

    ssi_tick #(
        .HALF_SEC_CYCLES (HALF_SEC_CYCLES)
    ) u_tick (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .tick_out   (tick),
        .blink_out  (blink)
    );

    always_comb begin
        inputs_ok = s[`SSI_IN_SAFE_A] & s[`SSI_IN_SAFE_B];
        ready     = s[`SSI_IN_SUPPLY] & inputs_ok;
        warning   = s[`SSI_IN_FAULT_A] | s[`SSI_IN_FAULT_B] | s[`SSI_IN_CROSS]
                  | s[`SSI_IN_TEMP] | s[`SSI_IN_BAD_ACT];
        protect   = (protect_count != 32'h0);
        // lowest code number wins among warnings
        if (s[`SSI_IN_FAULT_A]) begin
            code = `SSI_CODE_OUT_A;
        end else if (s[`SSI_IN_FAULT_B]) begin
            code = `SSI_CODE_OUT_B;
        end else if (s[`SSI_IN_CROSS]) begin
            code = `SSI_CODE_CROSS;
        end else if (s[`SSI_IN_TEMP]) begin
            code = `SSI_CODE_TEMP;
        end else if (s[`SSI_IN_BAD_ACT]) begin
            code = `SSI_CODE_ACTUATOR;
        end else begin
            code = `SSI_CODE_NONE;
        end
    end

    always_comb begin
        next_taught_prev = s[`SSI_IN_TAUGHT];

        // internal error latch: set wins, clear needs cause gone and an open-close cycle
        next_err_latched  = err_latched;
        next_guard_opened = guard_opened;
        // only an opening after the cause has gone counts towards the clear
        if (err_latched && !s[`SSI_IN_INTERNAL] && !s[`SSI_IN_ACTUATOR]) begin
            next_guard_opened = 1'b1;
        end
        if (s[`SSI_IN_INTERNAL]) begin
            next_err_latched  = 1'b1;
            next_guard_opened = 1'b0;
        end else if (err_latched && guard_opened && s[`SSI_IN_ACTUATOR]) begin
            next_err_latched  = 1'b0;
            next_guard_opened = 1'b0;
        end
        if (!err_latched) begin
            next_guard_opened = 1'b0;
        end

        // warning escalation timer, restarts whenever the warning drops
        next_warn_count   = warn_count;
        next_warn_expired = warn_expired;
        if (!warning) begin
            next_warn_count   = 32'h0;
            next_warn_expired = 1'b0;
        end else if (tick && !warn_expired) begin
            next_warn_count = warn_count + 32'h1;
            if (warn_count >= 32'(WARN_PHASES - 1)) begin
                next_warn_expired = 1'b1;
            end
        end

        // tamper protection: loaded on teach, reloaded while supply is lost
        next_protect_count = protect_count;
        if (s[`SSI_IN_TAUGHT] && !taught_prev) begin
            next_protect_count = 32'(PROTECT_PHASES);
        end else if (protect && !s[`SSI_IN_SUPPLY]) begin
            next_protect_count = 32'(PROTECT_PHASES);
        end else if (protect && tick) begin
            next_protect_count = protect_count - 32'h1;
        end

        // red pulse group sequencer, each pulse and each gap one half-second phase
        next_code_state  = code_state;
        next_pulse_count = pulse_count;
        next_active_code = active_code;
        unique case (code_state)
            ssi_pkg::SSI_IDLE: begin
                if (code != `SSI_CODE_NONE) begin
                    next_active_code = code;
                    next_pulse_count = 3'h1;
                    next_code_state  = ssi_pkg::SSI_ON;
                end
            end
            ssi_pkg::SSI_ON: begin
                if (tick) begin
                    next_code_state = ssi_pkg::SSI_OFF;
                end
            end
            ssi_pkg::SSI_OFF: begin
                if (tick) begin
                    if (pulse_count >= active_code) begin
                        next_pulse_count = 3'h0;
                        next_code_state  = ssi_pkg::SSI_PAUSE;
                    end else begin
                        next_pulse_count = pulse_count + 3'h1;
                        next_code_state  = ssi_pkg::SSI_ON;
                    end
                end
            end
            ssi_pkg::SSI_PAUSE: begin
                // pause is longer than the one-phase gap so groups stay countable
                if (tick) begin
                    next_pulse_count = pulse_count + 3'h1;
                    if (pulse_count >= 3'(`SSI_PAUSE_PHASES - 1)) begin
                        next_pulse_count = 3'h0;
                        next_code_state  = ssi_pkg::SSI_IDLE;
                    end
                end
            end
        endcase

        // outputs
        next_enable = ready & s[`SSI_IN_ACTUATOR] & ~err_latched & ~warn_expired
                    & ~s[`SSI_IN_TEACH] & ~protect;
        next_diag   = next_enable & ~warning;

        if (!inputs_ok || protect) begin
            next_green = blink;
        end else begin
            next_green = ready;
        end

        if (err_latched || s[`SSI_IN_TEACH]) begin
            next_red = 1'b1;
        end else if (warning) begin
            next_red = (code_state == ssi_pkg::SSI_ON);
        end else begin
            next_red = 1'b0;
        end

        if (s[`SSI_IN_TEACH]) begin
            next_yellow = blink;
        end else if (s[`SSI_IN_ACTUATOR] && s[`SSI_IN_LIMIT]) begin
            next_yellow = blink;
        end else begin
            next_yellow = s[`SSI_IN_ACTUATOR];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            err_latched   <= 1'b0;
            guard_opened  <= 1'b0;
            warn_count    <= 32'h0;
            warn_expired  <= 1'b0;
            protect_count <= 32'h0;
            taught_prev   <= 1'b0;
            code_state    <= ssi_pkg::SSI_IDLE;
            pulse_count   <= 3'h0;
            active_code   <= `SSI_CODE_NONE;
            green         <= 1'b0;
            red           <= 1'b0;
            yellow        <= 1'b0;
            diag          <= 1'b0;
            enable        <= 1'b0;
        end else begin
            err_latched   <= next_err_latched;
            guard_opened  <= next_guard_opened;
            warn_count    <= next_warn_count;
            warn_expired  <= next_warn_expired;
            protect_count <= next_protect_count;
            taught_prev   <= next_taught_prev;
            code_state    <= next_code_state;
            pulse_count   <= next_pulse_count;
            active_code   <= next_active_code;
            green         <= next_green;
            red           <= next_red;
            yellow        <= next_yellow;
            diag          <= next_diag;
            enable        <= next_enable;
        end
    end

    assign led_green_out       = green;
    assign led_red_out         = red;
    assign led_yellow_out      = yellow;
    assign diag_out            = diag;
    assign safety_output_a_out = enable;
    assign safety_output_b_out = enable;
endmodule

// ---- include/ssi_consts.svh ----
// Contract
// - green is lit steadily while supply and both safety inputs are present and no post-teach inhibit runs.
// - green blinks at 1 Hz while either safety input or both lack voltage.
// - yellow is lit whenever an actuator is in range, except while teaching, when it blinks.
// - yellow blinks at 1 Hz instead while the actuator sits in the limit zone.
// - faults show as red pulse groups: 1 for output a, 2 for output b, 3 for a cross-wire.
// - over-temperature shows as 4 red pulses and a wrong or broken actuator as 5.
// - red is steady for an internal fault; steady red with blinking yellow means teaching.
// - an internal error cuts both outputs and stays latched until cause gone and guard cycled.
// - a warning drives diagnostics low and blinks red while the outputs stay enabled.
// - a warning clears by itself once its cause is gone.
// - a warning held for 30 minutes also cuts both outputs, red keeps blinking.
// - diagnostics is high only when actuated, outputs enabled and no warning, else low.
// - after a teach, outputs are inhibited 10 minutes with green blinking; power loss restarts it.
`ifndef SSI_CONSTS_SVH
`define SSI_CONSTS_SVH
`define SSI_CLK_HZ          20000000
`define SSI_HALF_SEC_MS     500
`define SSI_MS_PER_SEC      1000
`define SSI_PHASES_PER_MIN  120
`define SSI_WARN_LIMIT_MIN  30
`define SSI_PROTECT_MIN     10
`define SSI_PAUSE_PHASES    4
`define SSI_CODE_NONE       3'h0
`define SSI_CODE_OUT_A      3'h1
`define SSI_CODE_OUT_B      3'h2
`define SSI_CODE_CROSS      3'h3
`define SSI_CODE_TEMP       3'h4
`define SSI_CODE_ACTUATOR   3'h5
`define SSI_IN_SUPPLY       0
`define SSI_IN_SAFE_A       1
`define SSI_IN_SAFE_B       2
`define SSI_IN_ACTUATOR     3
`define SSI_IN_LIMIT        4
`define SSI_IN_FAULT_A      5
`define SSI_IN_FAULT_B      6
`define SSI_IN_CROSS        7
`define SSI_IN_TEMP         8
`define SSI_IN_BAD_ACT      9
`define SSI_IN_INTERNAL     10
`define SSI_IN_TEACH        11
`define SSI_IN_TAUGHT       12
`define SSI_IN_COUNT        13
`endif

// ---- include/ssi_pkg.sv ----
package ssi_pkg;
    typedef enum logic [1:0] {
        SSI_IDLE  = 2'b00,
        SSI_ON    = 2'b01,
        SSI_OFF   = 2'b10,
        SSI_PAUSE = 2'b11
    } ssi_code_state_t;
endpackage

// ---- src/ssi_tick.sv ----
`timescale 1ns/1ps
`include "ssi_consts.svh"
module ssi_tick #(
    parameter int HALF_SEC_CYCLES = `SSI_CLK_HZ / `SSI_MS_PER_SEC * `SSI_HALF_SEC_MS
) (
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rstn_in,
    // half-second phase outputs
    output logic      tick_out,
    output logic      blink_out
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic        blink;
    logic        next_blink;
    logic        tick;
    logic        next_tick;

    always_comb begin
        next_tick  = 1'b0;
        next_blink = blink;
        next_count = count + 32'h1;
        if (count >= 32'(HALF_SEC_CYCLES - 1)) begin
            next_count = 32'h0;
            next_tick  = 1'b1;
            next_blink = ~blink;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            count <= 32'h0;
            blink <= 1'b0;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            blink <= next_blink;
            tick  <= next_tick;
        end
    end

    assign tick_out  = tick;
    assign blink_out = blink;
endmodule

// ---- test/ssi_plc_model.sv ----
`timescale 1ns/1ps
module ssi_plc_model (
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rstn_in,
    // sensor side
    input  wire logic diag_in,
    input  wire logic enable_in,
    // controller side
    output logic      stop_req_out
);
    logic next_stop_req;
    // diag low with outputs still on asks for a controlled stop, not an e-stop
    always_comb begin
        next_stop_req = !diag_in && enable_in;
    end
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) stop_req_out <= 1'b0;
        else stop_req_out <= next_stop_req;
    end
endmodule

// ---- test/ssi_core_sva.sv ----
`timescale 1ns/1ps
module ssi_core_chk #(parameter int HALF_SEC_CYCLES = 4) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic supply_ok_in,
    input wire logic safety_input_a_in,
    input wire logic actuator_present_in,
    input wire logic fault_output_a_in,
    input wire logic internal_fault_in,
    input wire logic teach_active_in,
    input wire logic led_green_out,
    input wire logic led_red_out,
    input wire logic led_yellow_out,
    input wire logic diag_out,
    input wire logic safety_output_a_out,
    input wire logic safety_output_b_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    int   g_cnt;
    int   next_g_cnt;
    logic green_q;
    // counts how long green holds one level while input a is missing
    always_comb begin
        next_g_cnt = g_cnt + 1;
        if (safety_input_a_in || !supply_ok_in || led_green_out != green_q) next_g_cnt = 0;
    end
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) g_cnt <= 0;
        else g_cnt <= next_g_cnt;
        green_q <= led_green_out;
    end
    chk_green_blinks: assert property (g_cnt < HALF_SEC_CYCLES + 4)
        else $error("green held too long");
    chk_diag_warn_low: assert property (fault_output_a_in [*5] |-> !diag_out)
        else $error("diag high during warning");
    chk_internal_cut: assert property (internal_fault_in [*5] |-> !safety_output_a_out)
        else $error("outputs on with internal fault");
    chk_outputs_pair: assert property (safety_output_a_out == safety_output_b_out)
        else $error("safety outputs differ");
    chk_diag_needs_out: assert property (diag_out |-> safety_output_a_out)
        else $error("diag high with outputs off");
    chk_yellow_absent: assert property ((!actuator_present_in && !teach_active_in) [*5]
        |-> !led_yellow_out)
        else $error("yellow without actuator");
    chk_red_internal: assert property (internal_fault_in [*5] |-> led_red_out)
        else $error("red off with internal fault");
    chk_warn_keeps_on: assert property ($rose(fault_output_a_in) && safety_output_a_out
        |-> safety_output_a_out [*6])
        else $error("warning cut outputs at once");
    cover property (fault_output_a_in && !safety_output_a_out);
    cover property ($rose(diag_out));
    cover property (internal_fault_in && led_red_out);
endmodule
bind ssi_core ssi_core_chk #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) i_chk (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .supply_ok_in(supply_ok_in),
    .safety_input_a_in(safety_input_a_in), .actuator_present_in(actuator_present_in),
    .fault_output_a_in(fault_output_a_in), .internal_fault_in(internal_fault_in),
    .teach_active_in(teach_active_in), .led_green_out(led_green_out),
    .led_red_out(led_red_out), .led_yellow_out(led_yellow_out), .diag_out(diag_out),
    .safety_output_a_out(safety_output_a_out), .safety_output_b_out(safety_output_b_out));

// ---- test/ssi_core_tb.sv ----
`timescale 1ns/1ps
`include "ssi_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module ssi_core_tb;
    localparam int          H   = 4;
    localparam logic [12:0] BAS = 13'h0007;
    localparam logic [12:0] ACT = 13'h000F;
    typedef struct { logic [12:0] p; logic [4:0] e; logic [4:0] m; } ssi_row_t;
    logic        clk_sys_in = 1'b0;
    logic        rstn_in    = 1'b0;
    logic [12:0] pins       = 13'h0007;
    logic        grn, red, yel, diag, out_a, out_b, stop_req;
    int          n_fail = 0;
    int          total_checks = 0;
    int          n;
    ssi_row_t    rows [8] = '{'{BAS, 5'h10, 5'h1F}, '{ACT, 5'h17, 5'h1F},
        '{13'h000D, 5'h04, 5'h0D}, '{13'h002F, 5'h01, 5'h03}, '{13'h004F, 5'h01, 5'h03},
        '{13'h008F, 5'h01, 5'h03}, '{13'h010F, 5'h01, 5'h03}, '{13'h020F, 5'h01, 5'h03}};
    always #25 clk_sys_in = ~clk_sys_in;
    ssi_core #(.HALF_SEC_CYCLES(H), .WARN_PHASES(6), .PROTECT_PHASES(6)) i_dut (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .supply_ok_in(pins[`SSI_IN_SUPPLY]),
        .safety_input_a_in(pins[`SSI_IN_SAFE_A]), .safety_input_b_in(pins[`SSI_IN_SAFE_B]),
        .actuator_present_in(pins[`SSI_IN_ACTUATOR]), .limit_zone_in(pins[`SSI_IN_LIMIT]),
        .fault_output_a_in(pins[`SSI_IN_FAULT_A]), .fault_output_b_in(pins[`SSI_IN_FAULT_B]),
        .cross_wire_in(pins[`SSI_IN_CROSS]), .over_temp_in(pins[`SSI_IN_TEMP]),
        .bad_actuator_in(pins[`SSI_IN_BAD_ACT]), .internal_fault_in(pins[`SSI_IN_INTERNAL]),
        .teach_active_in(pins[`SSI_IN_TEACH]), .teach_done_in(pins[`SSI_IN_TAUGHT]),
        .led_green_out(grn), .led_red_out(red), .led_yellow_out(yel), .diag_out(diag),
        .safety_output_a_out(out_a), .safety_output_b_out(out_b));
    ssi_plc_model i_plc (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .diag_in(diag),
        .enable_in(out_a), .stop_req_out(stop_req));
    task drive(input logic [12:0] v);
        @(posedge clk_sys_in);
        pins <= v;
    endtask
    task wt(input int c);
        repeat (c) @(posedge clk_sys_in);
        #1;
    endtask
    // pulses between two pauses; a gap is one phase, a pause far longer
    task count_red(output int cnt);
        int low;
        int st;
        low = 0;
        st = 0;
        cnt = 0;
        repeat (600) begin
            @(posedge clk_sys_in);
            #1;
            if (red === 1'b1) begin
                if (low >= 3 * H) st++;
                if (st == 1 && low > 0) cnt++;
                low = 0;
            end else low++;
            if (st == 2) break;
        end
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (8000) @(posedge clk_sys_in);
        n_fail++;
        close_out();
    end
    initial begin
        wt(11);
        `CHK("reset", 5'h00, {grn, red, yel, diag, out_a})
        @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        wt(8);
        foreach (rows[i]) begin
            drive(rows[i].p);
            wt(8);
            `CHK("row", rows[i].e, {grn, red, yel, diag, out_a} & rows[i].m)
            drive(ACT);
            wt(8);
        end
        $display("done table");
        for (int c = 1; c <= 5; c++) begin
            drive(ACT | (13'h0001 << (4 + c)));
            count_red(n);
            `CHK("pulses", c, n)
            drive(ACT);
            wt(8);
        end
        drive(ACT | 13'h0120);
        count_red(n);
        `CHK("priority", 1, n)
        drive(ACT);
        wt(8);
        $display("done codes");
        drive(ACT | 13'h0040);
        wt(10);
        `CHK("warn out", 1'b1, out_a)
        `CHK("plc stop", 1'b1, stop_req)
        wt(40);
        `CHK("timeout", 2'b00, {out_a, out_b})
        count_red(n);
        `CHK("timeout code", 2, n)
        drive(ACT);
        wt(8);
        `CHK("warn clear", 3'b111, {diag, out_a, out_b})
        $display("done warning");
        drive(ACT | 13'h0400);
        wt(8);
        `CHK("internal", 2'b10, {red, out_a})
        drive(BAS | 13'h0400);
        wt(8);
        drive(ACT);
        wt(8);
        `CHK("latched", 1'b0, out_a)
        drive(BAS);
        wt(8);
        drive(ACT);
        wt(8);
        `CHK("cleared", 1'b1, out_a)
        drive(ACT | 13'h0800);
        wt(8);
        `CHK("teach", 2'b10, {red, diag})
        drive(ACT | 13'h1000);
        wt(8);
        `CHK("protect", 1'b0, out_a)
        drive(ACT & 13'h1FFE);
        wt(8);
        drive(ACT);
        wt(12);
        `CHK("restart", 1'b0, out_a)
        wt(50);
        `CHK("expired", 1'b1, out_a)
        drive(ACT | 13'h0010);
        n = 0;
        repeat (24) begin
            wt(1);
            if (yel === 1'b0) n++;
        end
        `CHK("limit", 1'b1, n > 2 && n < 20)
        $display("done misc");
        close_out();
    end
endmodule
